// File: design/hsis_map.svh
/*
   Constants of the host serial interface select block: strap codes,
   uart defaults and timing counts.
   Assumes inclusion by the package and the design modules by bare name.
*/
`ifndef HSIS_MAP_SVH
`define HSIS_MAP_SVH

// strap codes {bit1, bit0}
`define HSIS_SEL_SYNC 2'h0
`define HSIS_SEL_UART 2'h1
`define HSIS_SEL_I2C 2'h2
`define HSIS_SEL_NONE 2'h3

// uart defaults
`define HSIS_DEF_START_BITS 2'h1
`define HSIS_DEF_STOP_BITS 2'h1
`define HSIS_DEF_PARITY 2'h0
`define HSIS_BAUD_DEF_BPS 32'd9600

// clock rate
`define HSIS_CLK_HZ 32'd200000000
`define HSIS_DEF_DIVISOR (16'(`HSIS_CLK_HZ / `HSIS_BAUD_DEF_BPS))

`endif

// File: design/hsis_pkg.sv
/*
   Types shared by the host serial interface select block.
   Assumes the constants header is on the include path.
*/
`include "hsis_map.svh"

package hsis_pkg;
   typedef enum logic [1:0] {
      HSIS_IF_SYNC,
      HSIS_IF_UART,
      HSIS_IF_I2C,
      HSIS_IF_NONE
   } hsis_if_t;

   typedef struct packed {
      logic [1:0] start_bits;
      logic [1:0] stop_bits;
      logic [1:0] parity;
      logic [15:0] divisor;
   } hsis_uart_cfg_t;
endpackage

// File: design/hsis_cfg_if.sv
/*
   Interface carrying uart configuration between the top and the uart
   configuration holder.
   Assumes one clock domain.
*/
`timescale 1ns/10ps
interface hsis_cfg_if;
   import hsis_pkg::*;
   logic wr;
   hsis_uart_cfg_t wr_cfg;
   hsis_uart_cfg_t cfg;
   modport top (output wr, output wr_cfg, input cfg);
   modport holder (input wr, input wr_cfg, output cfg);
endinterface

// File: design/hsis_uart_cfg.sv
/*
   Holder of the uart settings; defaults at reset, updated by
   configuration messages.
   Assumes the write strobe is synchronous to i_ref_clk.
*/
`timescale 1ns/10ps
`include "hsis_map.svh"
module hsis_uart_cfg (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // configuration link
   hsis_cfg_if.holder cfg_port
);
   import hsis_pkg::*;

   hsis_uart_cfg_t cfg_r;
   hsis_uart_cfg_t cfg_nxt;
   localparam hsis_uart_cfg_t DEF_CFG = '{
      start_bits: `HSIS_DEF_START_BITS,
      stop_bits: `HSIS_DEF_STOP_BITS,
      parity: `HSIS_DEF_PARITY,
      divisor: `HSIS_DEF_DIVISOR
   };

   // next settings: kept until a new message
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_port.wr) begin
         cfg_nxt = cfg_port.wr_cfg;
      end
   end

   // register, reset restores defaults
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cfg_r <= DEF_CFG;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   assign cfg_port.cfg = cfg_r;

   a_cfg_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !cfg_port.wr |=> cfg_r == $past(cfg_r))
      else $error("uart settings changed without a message");
endmodule

// File: design/hsis_top.sv
/*
   Host serial interface select and control: strap decode, uart
   enable, uart settings, message ready and standby exit.
   Assumes straps stable out of reset and inputs synchronous to i_ref_clk.
*/
`timescale 1ns/10ps
`include "hsis_map.svh"

module hsis_top (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // straps and clock speed
   input wire logic i_if_select_bit0,
   input wire logic i_if_select_bit1,
   input wire logic i_clk_fast,
   // messages from the core
   input wire logic i_msg_pending,
   input wire logic i_msg_taken,
   input wire logic i_uart_config_request_msg,
   input wire hsis_pkg::hsis_uart_cfg_t i_uart_cfg,
   // standby control
   input wire logic i_standby_enter,
   input wire logic i_standby_exit_in,
   // status out
   output hsis_pkg::hsis_if_t o_if_mode,
   output logic o_uart_enable,
   output hsis_pkg::hsis_uart_cfg_t o_uart_cfg,
   output logic o_message_ready_out,
   output logic o_standby,
   output logic o_standby_exit_indication_msg
);
   import hsis_pkg::*;

   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} hsis_pwr_t;

   hsis_cfg_if cfg_bus ();

   hsis_if_t mode_r, mode_nxt;
   logic uart_en_r, uart_en_nxt;
   logic mrdy_r, mrdy_nxt;
   logic exit_r, exit_nxt;
   logic exit_ind_r, exit_ind_nxt;
   logic strap_cap_r, strap_cap_nxt;
   hsis_pwr_t pwr_r, pwr_nxt;
   logic [1:0] strap;

   assign strap = {i_if_select_bit1, i_if_select_bit0};

   // uart settings holder
   hsis_uart_cfg u_cfg (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .cfg_port(cfg_bus.holder)
   );

   // config message only accepted while uart is usable
   assign cfg_bus.wr = i_uart_config_request_msg && uart_en_r;
   assign cfg_bus.wr_cfg = i_uart_cfg;

   // strap decode captured once after reset release
   always_comb begin
      mode_nxt = mode_r;
      strap_cap_nxt = 1'b1;
      if (!strap_cap_r) begin
         unique case (strap)
            `HSIS_SEL_UART: mode_nxt = HSIS_IF_UART;
            `HSIS_SEL_I2C: mode_nxt = HSIS_IF_I2C;
            `HSIS_SEL_SYNC: mode_nxt = HSIS_IF_SYNC;
            `HSIS_SEL_NONE: mode_nxt = HSIS_IF_NONE;
         endcase
      end
      uart_en_nxt = (mode_nxt == HSIS_IF_UART) && !i_clk_fast;
   end

   // message ready: set wins over take
   always_comb begin
      mrdy_nxt = mrdy_r;
      if (i_msg_taken) begin
         mrdy_nxt = 1'b0;
      end
      if (i_msg_pending) begin
         mrdy_nxt = 1'b1;
      end
   end

   // standby sequencing: exit on falling standby exit input
   always_comb begin
      pwr_nxt = pwr_r;
      exit_nxt = i_standby_exit_in;
      exit_ind_nxt = 1'b0;
      unique case (pwr_r)
         ST_RUN: begin
            if (i_standby_enter) begin
               pwr_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (exit_r && !i_standby_exit_in) begin
               pwr_nxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            pwr_nxt = ST_RUN;
            exit_ind_nxt = 1'b1;
         end
      endcase
   end

   // state registers
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mode_r <= HSIS_IF_SYNC;
         uart_en_r <= 1'b0;
         strap_cap_r <= 1'b0;
         mrdy_r <= 1'b0;
         pwr_r <= ST_RUN;
         exit_r <= 1'b0;
         exit_ind_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         uart_en_r <= uart_en_nxt;
         strap_cap_r <= strap_cap_nxt;
         mrdy_r <= mrdy_nxt;
         pwr_r <= pwr_nxt;
         exit_r <= exit_nxt;
         exit_ind_r <= exit_ind_nxt;
      end
   end

   // outputs
   assign o_if_mode = mode_r;
   assign o_uart_enable = uart_en_r;
   assign o_uart_cfg = cfg_bus.cfg;
   assign o_message_ready_out = mrdy_r;
   assign o_standby = (pwr_r == ST_SLEEP);
   assign o_standby_exit_indication_msg = exit_ind_r;

   a_uart_fast_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      i_clk_fast |=> !o_uart_enable)
      else $error("uart enabled with fast clock");
   a_uart_strap_sel: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_uart_enable |-> o_if_mode == HSIS_IF_UART)
      else $error("uart enabled without uart strap");
   a_mode_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      strap_cap_r |=> o_if_mode == $past(o_if_mode))
      else $error("interface mode changed after strap capture");
   a_exit_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_standby_exit_indication_msg |=> !o_standby_exit_indication_msg)
      else $error("standby exit indication longer than one cycle");
   a_mrdy_set: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      i_msg_pending |=> o_message_ready_out)
      else $error("message ready not raised");
   a_mrdy_clear: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      i_msg_taken && !i_msg_pending |=> !o_message_ready_out)
      else $error("message ready not cleared");
   a_standby_wake: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      o_standby && $fell(i_standby_exit_in) |=> ##1 o_standby_exit_indication_msg)
      else $error("standby exit not indicated");
   a_cfg_default: assert property (@(posedge i_ref_clk)
      $rose(i_reset_n) |-> o_uart_cfg.divisor == `HSIS_DEF_DIVISOR)
      else $error("uart default divisor wrong");
   a_cfg_refuse: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !o_uart_enable |=> o_uart_cfg == $past(o_uart_cfg))
      else $error("uart settings changed while uart off");
   a_i2c_strap: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $rose(strap_cap_r) && $past(strap) == `HSIS_SEL_I2C |-> o_if_mode == HSIS_IF_I2C)
      else $error("i2c strap not decoded");
endmodule

// File: verification/hsis_host.sv
/*
   host model: straps, standby exit line and amplifier mute.
   assumes one clock shared with the device.
*/
`timescale 1ns/10ps
module hsis_host (
   // clock, reset and requests
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [1:0] i_sel,
   input wire logic i_sleep,
   input wire logic i_standby,
   input wire logic i_exit_ind,
   // pins toward the device, and the mute toward the amplifier
   output logic o_if_select_bit0,
   output logic o_if_select_bit1,
   output logic o_standby_exit_in,
   output logic o_mute_n
);
   // 150 ms of i_ref_clk
   localparam int HOLD_CYC = 30000000;
   logic [24:0] hold_r;
   logic muted_r;

   // straps; the undefined pair is never driven
   assign o_if_select_bit0 = i_sel[0] & ~i_sel[1];
   assign o_if_select_bit1 = i_sel[1] & ~i_sel[0];

   // mute kept after reset release until the hold count ends
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         hold_r <= 25'h0;
      end else if (hold_r != 25'(HOLD_CYC)) begin
         hold_r <= hold_r + 25'h1;
      end
   end

   // mute first, exit line high only once in standby, unmute on indication
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         muted_r <= 1'b1;
         o_standby_exit_in <= 1'b0;
      end else begin
         o_standby_exit_in <= i_sleep & (i_standby | o_standby_exit_in);
         if (i_sleep) begin
            muted_r <= 1'b1;
         end else if (i_exit_ind) begin
            muted_r <= 1'b0;
         end
      end
   end

   // active low mute toward the amplifier
   assign o_mute_n = ~muted_r & (hold_r == 25'(HOLD_CYC));
endmodule

// File: verification/host_serial_interface_select_tb.sv
/*
   self-checking bench of the interface select block.
   assumes the design sources and the host model are compiled first.
*/
`timescale 1ns/10ps
`include "hsis_map.svh"
module host_serial_interface_select_tb;
   import hsis_pkg::*;
   logic i_ref_clk = 0, i_reset_n = 0, fast = 0, pend = 0, tk = 0;
   logic req = 0, enter = 0, sleep = 0;
   logic [1:0] sel = 2'h1;
   logic b0, b1, xin, mute_n, ready, en, stby, ind, exp_r;
   hsis_uart_cfg_t cfg_in = '0, dflt, cfg_out;
   hsis_if_t mode;
   int errors = 0, checks = 0, cycles = 0, n;

   // host side model
   hsis_host host (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sel(sel), .i_sleep(sleep),
      .i_standby(stby), .i_exit_ind(ind), .o_if_select_bit0(b0), .o_if_select_bit1(b1),
      .o_standby_exit_in(xin), .o_mute_n(mute_n));
   hsis_top dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_if_select_bit0(b0),
      .i_if_select_bit1(b1), .i_clk_fast(fast), .i_msg_pending(pend), .i_msg_taken(tk),
      .i_uart_config_request_msg(req), .i_uart_cfg(cfg_in), .i_standby_enter(enter),
      .i_standby_exit_in(xin), .o_if_mode(mode), .o_uart_enable(en), .o_uart_cfg(cfg_out),
      .o_message_ready_out(ready), .o_standby(stby), .o_standby_exit_indication_msg(ind));

   // clock and hang limit
   always #2.5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         conclude();
      end
   end

   task cyc();
      @(posedge i_ref_clk);
   endtask

   task chk(string nm, logic [31:0] e, logic [31:0] s);
      checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask

   // straps and clock speed change only while the device is held in reset
   task rst(input logic [1:0] s, input logic f);
      cyc();
      i_reset_n <= 1'b0;
      cyc();
      sel <= s;
      fast <= f;
      repeat (19) cyc();
      i_reset_n <= 1'b1;
      repeat (3) cyc();
      #1;
   endtask

   // uart usable only on its strap with the slow clock
   function automatic logic uart_ok(logic [1:0] s, logic f);
      return (s == `HSIS_SEL_UART) && !f;
   endfunction

   task conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      dflt = {`HSIS_DEF_START_BITS, `HSIS_DEF_STOP_BITS, `HSIS_DEF_PARITY, `HSIS_DEF_DIVISOR};
      n = $urandom(32'h7a1a51d8);
      // one pass each for the sync, uart and i2c strap codes, uart again with the fast clock
      for (int k = 0; k < 4; k++) begin
         rst((k == 3) ? 2'h1 : 2'(k), k == 3);
         chk("mode", 32'(sel), 32'(mode));
         chk("uart enable", 32'(uart_ok(sel, fast)), 32'(en));
         chk("uart cfg", 32'(dflt), 32'(cfg_out));
         chk("mute", 32'h0, 32'(mute_n));
         cyc();
         cfg_in <= 22'($urandom);
         req <= 1'b1;
         cyc();
         req <= 1'b0;
         #1;
         chk("uart cfg", 32'(uart_ok(sel, fast) ? cfg_in : dflt), 32'(cfg_out));
         repeat (5) cyc();
         #1 chk("uart cfg kept", 32'(uart_ok(sel, fast) ? cfg_in : dflt), 32'(cfg_out));
         $display("test strap %0d done", k);
      end
      // message ready against its own model
      exp_r = 1'b0;
      for (int i = 0; i < 200; i++) begin
         cyc();
         exp_r = pend | (exp_r & ~tk);
         pend <= ($urandom % 4) == 0;
         tk <= 1'($urandom);
         #1 chk("message ready", 32'(exp_r), 32'(ready));
      end
      $display("test message ready done");
      // mute, standby entry, exit line high then low, one indication pulse
      cyc();
      pend <= 1'b0;
      sleep <= 1'b1;
      cyc();
      enter <= 1'b1;
      cyc();
      enter <= 1'b0;
      #1 chk("standby", 32'h1, 32'(stby));
      repeat (3) cyc();
      sleep <= 1'b0;
      n = 0;
      while (ind !== 1'b1 && n < 8) begin
         cyc();
         #1;
         n++;
      end
      chk("exit indication", 32'h1, 32'(ind));
      chk("standby", 32'h0, 32'(stby));
      cyc();
      #1 chk("exit indication", 32'h0, 32'(ind));
      $display("test standby done");
      conclude();
   end
endmodule
